/* src/pm_pkg.sv */
// package for the power-state pin controller: modes, config and sampled pin group
// assumes a single 100 MHz clock domain and active-low asynchronous reset
package pm_pkg;

    // one-hot operating modes
    typedef enum logic [4:0] {
        MODE_HYPER = 5'h01,
        MODE_HIGH = 5'h02,
        MODE_LOW = 5'h04,
        MODE_STANDBY = 5'h08,
        MODE_SUSPEND = 5'h10
    } pm_mode_e;

    // configuration held outside this block (configuration index space)
    localparam logic [7:0] PIN_CFG_INDEX = 8'h50;
    localparam logic EDGE_FALL = 1'h0;
    localparam logic EDGE_RISE = 1'h1;

    typedef struct packed {
        logic sus_edge_rise;   // active edge of suspend_resume_pin
        logic resume_to_low;   // resume target: 1 low-speed, 0 high-speed
        logic ac_disables_pm;  // ac_power_present disables power management
    } pm_cfg_s;

    // synchronised pin group
    typedef struct packed {
        logic suspend_resume_pin;
        logic battery_dead_input;
        logic ac_power_present;
    } pm_pins_s;

    localparam int PIN_COUNT = 3;
    localparam logic [2:0] SYNC_RESET = 3'h7;  // pins idle high at reset

endpackage : pm_pkg

/* src/pin_sync.sv */
// three-stage synchroniser with agreement filter for the power-management pins
// assumes asynchronous pin inputs; output changes only when stages 2 and 3 agree
module pin_sync (
    input wire logic CLK,
    input wire logic NRST,
    input wire pm_pkg::pm_pins_s PIN_IN,
    output pm_pkg::pm_pins_s PIN_OUT
);
    import pm_pkg::*;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] clean;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // stage 1 is read only by stage 2; the filter looks at stages 2 and 3
    always_comb begin
        next_st = st;
        next_st.s1 = PIN_IN;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.clean[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '{s1: SYNC_RESET, s2: SYNC_RESET, s3: SYNC_RESET, clean: SYNC_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign PIN_OUT = st.clean;

endmodule : pin_sync

/* src/power_state_pin_control.sv */
// power-state pin controller: suspend/resume pin, dead-battery pin, ac-supply pin
// assumes CFG is static software configuration and pins are asynchronous
// assumes ALL_CLEAR and the speed request come from logic on this clock
// limitation: a pin pulse shorter than two clocks is filtered away on purpose
// How it works
// - active edge while running enters suspend
// - active edge in suspend resumes high/low
// - software selects active suspend/resume edge
// - dead-battery falling edge drives latched output low
// - dead-battery edge forces suspend, output reports it
// - latched output released only by all-clear
// - ac present with option disables management
module power_state_pin_control (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SUSPEND_RESUME_PIN,
    input wire logic BATTERY_DEAD_INPUT,
    input wire logic AC_POWER_PRESENT,
    input wire pm_pkg::pm_cfg_s CFG,
    input wire logic SPEED_REQ_VALID,
    input wire pm_pkg::pm_mode_e SPEED_REQ,
    input wire logic ALL_CLEAR,
    output pm_pkg::pm_mode_e MODE,
    output logic LATCHED_BATTERY_DEAD_OUT_N,
    output logic PM_DISABLED
);
    import pm_pkg::*;

    typedef struct packed {
        pm_pins_s prev;
        pm_mode_e mode;
        logic batt_latched;
        logic pm_off;
    } ctl_s;

    ctl_s st;
    ctl_s next_st;
    pm_pins_s raw_pins;
    pm_pins_s pins;
    logic sus_edge;
    logic batt_fall;

    // group the three pins so they pass the filter together
    assign raw_pins.suspend_resume_pin = SUSPEND_RESUME_PIN;
    assign raw_pins.battery_dead_input = BATTERY_DEAD_INPUT;
    assign raw_pins.ac_power_present = AC_POWER_PRESENT;

    // pins are asynchronous: filter before any edge is looked at
    // the filter costs about five clocks from pin to state, far below any supply timescale
    pin_sync u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .PIN_IN(raw_pins),
        .PIN_OUT(pins)
    );

    // edge detection on the filtered level gives one event per edge
    always_comb begin
        if (CFG.sus_edge_rise == EDGE_RISE) begin
            sus_edge = pins.suspend_resume_pin && !st.prev.suspend_resume_pin;
        end else begin
            sus_edge = !pins.suspend_resume_pin && st.prev.suspend_resume_pin;
        end
        batt_fall = !pins.battery_dead_input && st.prev.battery_dead_input;
    end

    // mode machine; dead battery has priority over the suspend/resume pin
    always_comb begin
        next_st = st;
        next_st.prev = pins;
        next_st.pm_off = pins.ac_power_present && CFG.ac_disables_pm;
        // release first so a fresh dead-battery edge in the same cycle wins
        if (ALL_CLEAR) begin
            next_st.batt_latched = 1'b0;
        end
        if (batt_fall) begin
            next_st.batt_latched = 1'b1;
        end
        case (st.mode)
            // running modes: dead battery first, then the pin, then software
            MODE_HYPER, MODE_HIGH, MODE_LOW, MODE_STANDBY: begin
                if (batt_fall) begin
                    next_st.mode = MODE_SUSPEND;
                end else if (sus_edge && !next_st.pm_off) begin
                    next_st.mode = MODE_SUSPEND;
                end else if (SPEED_REQ_VALID && SPEED_REQ != MODE_SUSPEND) begin
                    next_st.mode = SPEED_REQ;
                end
            end
            MODE_SUSPEND: begin
                // no resume while the dead-battery latch is still set
                if (sus_edge && !st.batt_latched && !batt_fall) begin
                    next_st.mode = CFG.resume_to_low ? MODE_LOW : MODE_HIGH;
                end else if (next_st.pm_off && !next_st.batt_latched) begin
                    // next-state latch, so a dead edge in this cycle keeps suspend
                    next_st.mode = MODE_HIGH;
                end
            end
            default: begin
                next_st.mode = MODE_HIGH;
            end
        endcase
    end

    // prev resets to the filter's reset level, so no false edge follows reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '{prev: pm_pins_s'(SYNC_RESET), mode: MODE_HIGH, batt_latched: 1'b0, pm_off: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    assign MODE = st.mode;
    assign LATCHED_BATTERY_DEAD_OUT_N = !st.batt_latched;
    assign PM_DISABLED = st.pm_off;

    // assertions: each watches what this block drives; reset disables them
    // stated on the filtered pins, since the raw pins reach the state five clocks late
    sequence s_batt_edge;
        !pins.battery_dead_input && st.prev.battery_dead_input;
    endsequence

    // software asks for suspend while running, with no pin event in the same cycle
    sequence s_soft_suspend_req;
        SPEED_REQ_VALID && (SPEED_REQ == MODE_SUSPEND) && (MODE != MODE_SUSPEND) && !batt_fall && !sus_edge;
    endsequence

    // an active edge while running that the ac option refuses
    sequence s_ac_refused_edge;
        sus_edge && (MODE != MODE_SUSPEND) && next_st.pm_off && !batt_fall;
    endsequence

    // a running cycle followed by a suspended one
    sequence s_enter_suspend;
        (MODE != MODE_SUSPEND) ##1 (MODE == MODE_SUSPEND);
    endsequence

    // a suspended cycle followed by a running one
    sequence s_leave_suspend;
        (MODE == MODE_SUSPEND) ##1 (MODE != MODE_SUSPEND);
    endsequence

    // dead battery path
    a_batt_forces_suspend: assert property (@(posedge CLK) disable iff (!NRST)
        s_batt_edge |=> (MODE == MODE_SUSPEND))
        else $error("dead battery edge did not force suspend");

    a_batt_latch_low: assert property (@(posedge CLK) disable iff (!NRST)
        s_batt_edge |=> !LATCHED_BATTERY_DEAD_OUT_N)
        else $error("latched output not low after dead battery edge");

    a_set_wins: assert property (@(posedge CLK) disable iff (!NRST)
        (batt_fall && ALL_CLEAR) |=> !LATCHED_BATTERY_DEAD_OUT_N)
        else $error("all-clear beat a fresh dead battery edge");

    a_latch_fall_cause: assert property (@(posedge CLK) disable iff (!NRST)
        $fell(LATCHED_BATTERY_DEAD_OUT_N) |-> $past(batt_fall))
        else $error("latched output went low without a dead battery edge");

    a_latch_reports_suspend: assert property (@(posedge CLK) disable iff (!NRST)
        $fell(LATCHED_BATTERY_DEAD_OUT_N) |-> (MODE == MODE_SUSPEND))
        else $error("latched output low but not in suspend");

    // latch release only through all-clear
    a_latch_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (!LATCHED_BATTERY_DEAD_OUT_N && !ALL_CLEAR) |=> !LATCHED_BATTERY_DEAD_OUT_N)
        else $error("latched output released without all-clear");

    a_latch_release: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(LATCHED_BATTERY_DEAD_OUT_N) |-> $past(ALL_CLEAR))
        else $error("latched output released without cause");

    a_no_early_resume: assert property (@(posedge CLK) disable iff (!NRST)
        (MODE == MODE_SUSPEND && !LATCHED_BATTERY_DEAD_OUT_N && !ALL_CLEAR) |=> (MODE == MODE_SUSPEND))
        else $error("left suspend while the dead battery latch was set");

    // suspend/resume pin path
    a_run_to_suspend: assert property (@(posedge CLK) disable iff (!NRST)
        (sus_edge && MODE != MODE_SUSPEND && !next_st.pm_off) |=> MODE == MODE_SUSPEND)
        else $error("active edge did not enter suspend");

    a_resume_target: assert property (@(posedge CLK) disable iff (!NRST)
        (sus_edge && MODE == MODE_SUSPEND && LATCHED_BATTERY_DEAD_OUT_N && !batt_fall)
        |=> (MODE == (CFG.resume_to_low ? MODE_LOW : MODE_HIGH)))
        else $error("resume went to wrong mode");

    a_edge_select: assert property (@(posedge CLK) disable iff (!NRST)
        sus_edge |-> (pins.suspend_resume_pin == CFG.sus_edge_rise))
        else $error("suspend edge of wrong polarity");

    a_soft_suspend_refused: assert property (@(posedge CLK) disable iff (!NRST)
        s_soft_suspend_req |=> (MODE != MODE_SUSPEND))
        else $error("software request entered suspend");

    a_entry_cause: assert property (@(posedge CLK) disable iff (!NRST)
        s_enter_suspend |-> ($past(sus_edge) || $past(batt_fall)))
        else $error("suspend entered without a pin event");

    a_leave_target: assert property (@(posedge CLK) disable iff (!NRST)
        s_leave_suspend |-> (MODE == MODE_HIGH || MODE == MODE_LOW))
        else $error("suspend left to a mode other than high or low speed");

    a_suspend_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (MODE == MODE_SUSPEND && !sus_edge && !next_st.pm_off) |=> (MODE == MODE_SUSPEND))
        else $error("suspend left without an active edge");

    // ac supply path
    a_ac_disable: assert property (@(posedge CLK) disable iff (!NRST)
        (pins.ac_power_present && CFG.ac_disables_pm) |=> PM_DISABLED)
        else $error("ac supply did not disable power management");

    a_ac_release: assert property (@(posedge CLK) disable iff (!NRST)
        !(pins.ac_power_present && CFG.ac_disables_pm) |=> !PM_DISABLED)
        else $error("power management disabled without ac and option");

    a_ac_blocks_suspend: assert property (@(posedge CLK) disable iff (!NRST)
        s_ac_refused_edge |=> (MODE != MODE_SUSPEND))
        else $error("suspend entered while power management was disabled");

    a_pm_off_resume: assert property (@(posedge CLK) disable iff (!NRST)
        (MODE == MODE_SUSPEND && next_st.pm_off && !next_st.batt_latched && !sus_edge) |=> (MODE == MODE_HIGH))
        else $error("disabled power management left the chip suspended");

    // filter path
    a_single_edge: assert property (@(posedge CLK) disable iff (!NRST)
        sus_edge |=> !sus_edge)
        else $error("one pin edge gave two requests");

endmodule : power_state_pin_control

/* verification/pm_supply_model.sv */
// supply-side model: battery monitor, power switch and ac detector pins
// assumes the bench asks for pin levels; pins move on clock edges only
module pm_supply_model (
    input wire logic CLK,
    input wire logic SUS_REQ,
    input wire logic DEAD_REQ,
    input wire logic AC_REQ,
    output logic SUS_PIN,
    output logic DEAD_PIN,
    output logic AC_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels are held for many cycles, so the pulse filter never eats them
    initial begin
        SUS_PIN = 1'h1;
        DEAD_PIN = 1'h1;
        AC_PIN = 1'h0;
    end
    always @(posedge CLK) begin
        SUS_PIN <= SUS_REQ;
        DEAD_PIN <= DEAD_REQ;
        AC_PIN <= AC_REQ;
    end
endmodule : pm_supply_model

/* verification/power_state_pin_control_bench.sv */
// bench for the power-state pin controller
// assumes the supply model drives the pins; cfg and speed requests come from here
module power_state_pin_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pm_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, sus = 1'h1, dead = 1'h1, ac = 1'h0;
    logic sus_pin, dead_pin, ac_pin, spd_v = 1'h0, clr = 1'h0, latch_n, pm_dis;
    pm_cfg_s cfg = '0;
    pm_mode_e spd = MODE_HIGH, mode;
    int miscompares = 0, tests_run = 0, cycles = 0;
    pm_supply_model u_pm_supply_model (.CLK(clk), .SUS_REQ(sus), .DEAD_REQ(dead), .AC_REQ(ac),
        .SUS_PIN(sus_pin), .DEAD_PIN(dead_pin), .AC_PIN(ac_pin));
    power_state_pin_control u_power_state_pin_control (.CLK(clk), .NRST(nrst),
        .SUSPEND_RESUME_PIN(sus_pin), .BATTERY_DEAD_INPUT(dead_pin), .AC_POWER_PRESENT(ac_pin),
        .CFG(cfg), .SPEED_REQ_VALID(spd_v), .SPEED_REQ(spd), .ALL_CLEAR(clr),
        .MODE(mode), .LATCHED_BATTERY_DEAD_OUT_N(latch_n), .PM_DISABLED(pm_dis));
    initial begin
        forever #5 clk = ~clk;
    end
    task end_of_test();
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // a hang counts as a mismatch and closes the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // bounded wait: the pin path is a few cycles, twelve leaves margin
    task await_mode(input pm_mode_e m);
        for (int i = 0; i < 12 && mode !== m; i++) @(posedge clk);
        chk(8'(mode), 8'(m));
    endtask : await_mode
    // one-cycle speed request, raised and dropped on rising edges
    task speed_pulse(input pm_mode_e m);
        spd <= m;
        spd_v <= 1'h1;
        tick(1);
        spd_v <= 1'h0;
    endtask : speed_pulse
    // software may not ask for suspend; only the pin or a dead battery enter it
    task t_speed_refused();
        speed_pulse(MODE_SUSPEND);
        tick(3);
        chk(8'(mode), 8'(MODE_HIGH));
    endtask : t_speed_refused
    task t_falling_edge();
        cfg <= '{EDGE_FALL, 1'h0, 1'h0};
        tick(4);
        sus <= 1'h0;
        await_mode(MODE_SUSPEND);
        sus <= 1'h1;
        tick(10);
        chk(8'(mode), 8'(MODE_SUSPEND));
        sus <= 1'h0;
        await_mode(MODE_HIGH);
    endtask : t_falling_edge
    task t_rising_from_hyper();
        speed_pulse(MODE_HYPER);
        await_mode(MODE_HYPER);
        cfg <= '{EDGE_RISE, 1'h1, 1'h0};
        tick(4);
        sus <= 1'h1;
        await_mode(MODE_SUSPEND);
        sus <= 1'h0;
        tick(10);
        chk(8'(mode), 8'(MODE_SUSPEND));
        sus <= 1'h1;
        await_mode(MODE_LOW);
    endtask : t_rising_from_hyper
    task t_dead_battery();
        dead <= 1'h0;
        await_mode(MODE_SUSPEND);
        chk(8'(latch_n), 8'h00);
        speed_pulse(MODE_LOW);
        tick(2);
        chk(8'(mode), 8'(MODE_SUSPEND));
        dead <= 1'h1;
        sus <= 1'h0;
        tick(10);
        sus <= 1'h1;
        tick(10);
        chk(8'(mode), 8'(MODE_SUSPEND));
        chk(8'(latch_n), 8'h00);
        clr <= 1'h1;
        tick(1);
        clr <= 1'h0;
        tick(3);
        chk(8'(latch_n), 8'h01);
    endtask : t_dead_battery
    // ac without the option changes nothing; with it, suspend is left and an edge is refused
    task t_ac_supply();
        ac <= 1'h1;
        tick(10);
        chk(8'(pm_dis), 8'h00);
        cfg <= '{EDGE_RISE, 1'h1, 1'h1};
        tick(8);
        chk(8'(pm_dis), 8'h01);
        chk(8'(mode), 8'(MODE_HIGH));
        sus <= 1'h0;
        tick(10);
        sus <= 1'h1;
        tick(10);
        chk(8'(mode == MODE_SUSPEND), 8'h00);
    endtask : t_ac_supply
    initial begin
        tick(3);
        nrst <= 1'h1;
        tick(5);
        chk(8'(mode), 8'(MODE_HIGH));
        chk(8'({latch_n, pm_dis}), 8'h02);
        t_speed_refused();
        t_falling_edge();
        t_rising_from_hyper();
        t_dead_battery();
        t_ac_supply();
        end_of_test();
    end
endmodule : power_state_pin_control_bench
